// file: hdl/program_sequencer.sv
// Program sequencer: program counter, vectors, return stack, cycle timing and wake-up
//
// Notes on behaviour
// - Program counter ten bits covers 1K words
// - Power-on reset starts fetch at 0x000
// - Software interrupt fetches from 0x001
// - All hardware interrupts enter at 0x008
// - Short jumps and calls reach 256 words
// - Medium jump reaches 512 words
// - Long jump and call reach everywhere
// - Calls and interrupts push next address
// - Returns pop top entry into counter
// - Instruction cycle is four clocks
// - Branches and taken skips take two cycles
// - Rolling-code words fetch as normal code
// - Standby wakes on seven events
// - Halt wakes on three events only
// - Wake-up raises interrupt and resumes running
// - Port B bit0 interrupt needs select and enable
`timescale 1ns/1ps
module program_sequencer (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_exec,
    input wire prog_seq_pkg::seq_op_t i_op,
    input wire logic [prog_seq_pkg::PC_WIDTH-1:0] i_target,
    input wire logic i_skip_taken,
    input wire logic i_slow_select,
    input wire logic i_enter_standby,
    input wire logic i_enter_halt,
    input wire logic i_irq_request,
    input wire logic i_irq_global_enable,
    input wire logic [5:0] i_wake_events,
    input wire logic i_port_b_bit0_ext_irq_pin,
    input wire logic i_ext_irq_pin_select,
    input wire logic i_ext_irq_enable,
    output logic [prog_seq_pkg::PC_WIDTH-1:0] o_pc,
    output logic o_fetch,
    output logic [1:0] o_phase,
    output logic o_cycle_end,
    output logic o_second_cycle,
    output prog_seq_pkg::power_mode_t o_mode,
    output logic o_wake_irq,
    output logic o_ext_irq,
    output logic o_irq_taken
);
    import prog_seq_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic [PC_WIDTH-1:0] pc;
    logic [1:0] phase;
    logic second_cycle;
    logic [PC_WIDTH-1:0] next_pc;
    logic push;
    logic pop;
    logic take_two;
    logic boundary;
    logic running;
    logic irq_accept;
    logic ext_sync1;
    logic ext_sync2;
    logic ext_prev;
    logic ext_edge;
    logic ext_irq_active;
    logic [WAKE_EVENTS-1:0] wake_vector;
    logic wake_hit;
    logic wake_pending;
    logic [PC_WIDTH-1:0] stack_top;
    power_mode_t mode;
    power_mode_t run_mode;

    function automatic logic [PC_WIDTH-1:0] page_join(
        input logic [PC_WIDTH-1:0] base,
        input logic [PC_WIDTH-1:0] tgt,
        input int bits
    );
        logic [PC_WIDTH-1:0] mask;
        mask = PC_WIDTH'((1 << bits) - 1);
        page_join = (base & ~mask) | (tgt & mask);
    endfunction

    // ****************************************
    // Instruction cycle timing
    // ****************************************
    assign boundary = (phase == CLOCKS_PER_CYCLE_M1);
    assign running = (mode == MODE_NORMAL) || (mode == MODE_SLOW);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= PHASE_RESET;
        end else if (running) begin
            phase <= phase + 2'h1;
        end else begin
            phase <= PHASE_RESET;
        end
    end

    // ****************************************
    // Next address selection
    // ****************************************
    assign irq_accept = boundary && running && !second_cycle && i_irq_request
        && i_irq_global_enable;

    always_comb begin
        next_pc = pc + 10'h001;
        push = 1'b0;
        pop = 1'b0;
        take_two = 1'b0;
        if (irq_accept) begin
            next_pc = HW_IRQ_VECTOR;
            push = 1'b1;
            take_two = 1'b1;
        end else if (i_exec) begin
            case (i_op)
                OP_SKIP: begin
                    if (i_skip_taken) begin
                        next_pc = pc + 10'h002;
                        take_two = 1'b1;
                    end
                end
                OP_SHORT_CALL, OP_SHORT_ABS_CALL: begin
                    next_pc = page_join(pc, i_target, SHORT_REACH_BITS);
                    push = 1'b1;
                    take_two = 1'b1;
                end
                OP_SHORT_ABS_JUMP: begin
                    next_pc = page_join(pc, i_target, SHORT_REACH_BITS);
                    take_two = 1'b1;
                end
                OP_MEDIUM_JUMP: begin
                    next_pc = page_join(pc, i_target, MEDIUM_REACH_BITS);
                    take_two = 1'b1;
                end
                OP_LONG_CALL: begin
                    next_pc = i_target;
                    push = 1'b1;
                    take_two = 1'b1;
                end
                OP_LONG_JUMP: begin
                    next_pc = i_target;
                    take_two = 1'b1;
                end
                OP_PLAIN_RETURN, OP_RETURN_LITERAL, OP_RETURN_IRQ: begin
                    next_pc = stack_top;
                    pop = 1'b1;
                    take_two = 1'b1;
                end
                OP_SOFT_IRQ: begin
                    next_pc = SOFT_IRQ_VECTOR;
                    push = 1'b1;
                    take_two = 1'b1;
                end
                default: begin
                    next_pc = pc + 10'h001;
                end
            endcase
        end
    end

    // ****************************************
    // Program counter and second cycle
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc <= RESET_VECTOR;
        end else if (boundary && running && !second_cycle) begin
            pc <= next_pc;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            second_cycle <= 1'b0;
        end else if (boundary && running) begin
            second_cycle <= !second_cycle && take_two;
        end
    end

    return_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_WIDTH)
    ) u_stack (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_push(boundary && running && !second_cycle && push),
        .i_pop(boundary && running && !second_cycle && pop),
        .i_data(pc + 10'h001),
        .o_top(stack_top)
    );

    // ****************************************
    // External interrupt pin
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_sync1 <= i_port_b_bit0_ext_irq_pin;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
        end
    end

    assign ext_irq_active = i_ext_irq_pin_select && i_ext_irq_enable;
    assign ext_edge = ext_irq_active && ext_sync2 && !ext_prev;

    // ****************************************
    // Power modes and wake-up
    // ****************************************
    // Vector order: timer0, timer1, timer2, watchdog, port B change, external, comparator
    assign wake_vector = {i_wake_events[5], ext_edge, i_wake_events[4:0]};
    assign run_mode = i_slow_select ? MODE_SLOW : MODE_NORMAL;

    always_comb begin
        case (mode)
            MODE_STANDBY: wake_hit = |(wake_vector & WAKE_STANDBY_MASK);
            MODE_HALT: wake_hit = |(wake_vector & WAKE_HALT_MASK);
            default: wake_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode <= MODE_NORMAL;
        end else if (wake_hit) begin
            mode <= run_mode;
        end else if (running && boundary && i_enter_halt) begin
            mode <= MODE_HALT;
        end else if (running && boundary && i_enter_standby) begin
            mode <= MODE_STANDBY;
        end else if (running) begin
            mode <= run_mode;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_pending <= 1'b0;
        end else begin
            wake_pending <= wake_hit;
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pc <= RESET_VECTOR;
            o_fetch <= 1'b0;
            o_phase <= PHASE_RESET;
            o_cycle_end <= 1'b0;
            o_second_cycle <= 1'b0;
            o_mode <= MODE_NORMAL;
            o_wake_irq <= 1'b0;
            o_ext_irq <= 1'b0;
            o_irq_taken <= 1'b0;
        end else begin
            o_pc <= pc;
            o_fetch <= running && (phase == PHASE_RESET);
            o_phase <= phase;
            o_cycle_end <= boundary && running;
            o_second_cycle <= second_cycle;
            o_mode <= mode;
            o_wake_irq <= wake_pending;
            o_ext_irq <= ext_edge;
            o_irq_taken <= irq_accept;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    reset_vector_a: assert property (@(posedge i_clk)
        $rose(i_rst_n) |-> pc == RESET_VECTOR)
        else $error("pc not at reset vector after reset");

    hw_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        irq_accept |=> pc == HW_IRQ_VECTOR)
        else $error("hardware interrupt did not reach its vector");

    soft_vector_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        boundary && running && !second_cycle && !irq_accept && i_exec
        && i_op == OP_SOFT_IRQ |=> pc == SOFT_IRQ_VECTOR)
        else $error("software interrupt did not reach its vector");

    cycle_four_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        running && boundary && running ##1 running[*3] |-> ##1 boundary)
        else $error("instruction cycle is not four clocks");

    pc_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !boundary |=> $stable(pc))
        else $error("pc changed inside an instruction cycle");

    two_cycle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        boundary && running && !second_cycle && take_two |=> second_cycle)
        else $error("branch did not take a second cycle");

    short_page_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        boundary && running && !second_cycle && !irq_accept && i_exec
        && i_op == OP_SHORT_ABS_JUMP |=> pc[9:8] == $past(pc[9:8]))
        else $error("short jump left its 256-word page");

    halt_wake_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        mode == MODE_HALT && !(|(wake_vector & WAKE_HALT_MASK)) |=> mode == MODE_HALT)
        else $error("halt woke on a disallowed event");

    wake_run_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wake_hit |=> running ##1 o_wake_irq)
        else $error("wake-up did not resume and raise interrupt");

    ext_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ext_sync2 && !ext_prev |=> o_ext_irq ==
        ($past(i_ext_irq_pin_select) && $past(i_ext_irq_enable)))
        else $error("external interrupt gating wrong");
endmodule

// file: shared/prog_seq_pkg.sv
// Package of constants and types for the program sequencer
package prog_seq_pkg;
    localparam int PC_WIDTH = 10;
    localparam int PROG_WORDS = 1024;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_PTR_WIDTH = 3;
    localparam logic [9:0] RESET_VECTOR = 10'h000;
    localparam logic [9:0] SOFT_IRQ_VECTOR = 10'h001;
    localparam logic [9:0] HW_IRQ_VECTOR = 10'h008;
    localparam logic [9:0] RESERVED_LO = 10'h3FE;
    localparam logic [9:0] ROLLING_CODE_LO = 10'h00E;
    localparam logic [9:0] ROLLING_CODE_HI = 10'h00F;
    localparam int SHORT_REACH_BITS = 8;
    localparam int MEDIUM_REACH_BITS = 9;
    localparam logic [1:0] CLOCKS_PER_CYCLE_M1 = 2'h3;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [6:0] WAKE_STANDBY_MASK = 7'h7F;
    localparam logic [6:0] WAKE_HALT_MASK = 7'h38;
    localparam int WAKE_EVENTS = 7;

    typedef enum logic [3:0] {
        OP_NEXT,
        OP_SKIP,
        OP_SHORT_CALL,
        OP_SHORT_ABS_JUMP,
        OP_SHORT_ABS_CALL,
        OP_MEDIUM_JUMP,
        OP_LONG_CALL,
        OP_LONG_JUMP,
        OP_PLAIN_RETURN,
        OP_RETURN_LITERAL,
        OP_RETURN_IRQ,
        OP_SOFT_IRQ
    } seq_op_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SLOW,
        MODE_STANDBY,
        MODE_HALT
    } power_mode_t;
endpackage

// file: hdl/return_stack.sv
// Eight-entry hardware return stack
`timescale 1ns/1ps
module return_stack #(
    parameter int DEPTH = prog_seq_pkg::STACK_DEPTH,
    parameter int WIDTH = prog_seq_pkg::PC_WIDTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [WIDTH-1:0] i_data,
    output logic [WIDTH-1:0] o_top
);
    import prog_seq_pkg::*;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [STACK_PTR_WIDTH-1:0] ptr;

    // Circular pointer: overflow wraps onto the oldest entry
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr <= '0;
        end else if (i_push) begin
            ptr <= ptr + 3'h1;
        end else if (i_pop) begin
            ptr <= ptr - 3'h1;
        end
    end

    // Entries clear on reset so a pop from an empty stack returns address 0
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (i_push) begin
            mem[ptr] <= i_data;
        end
    end

    assign o_top = mem[ptr - 3'h1];
endmodule

// file: verification/prog_mem_model.sv
// Program memory model that feeds instructions to the sequencer
`timescale 1ns/1ps
module prog_mem_model (
    input wire logic [prog_seq_pkg::PC_WIDTH-1:0] i_addr,
    output prog_seq_pkg::seq_op_t o_op,
    output logic [prog_seq_pkg::PC_WIDTH-1:0] o_target,
    output logic o_exec
);
    import prog_seq_pkg::*;
    seq_op_t op_mem [PROG_WORDS];
    logic [PC_WIDTH-1:0] tgt_mem [PROG_WORDS];
    // Low while the current word is not handed over as an instruction
    bit exec_on = 1'b1;
    // ****************************************
    // Memory image
    // ****************************************
    // Reserved top words never receive code
    task automatic load(input int a, input seq_op_t op, input logic [PC_WIDTH-1:0] t);
        if (a < RESERVED_LO) begin
            op_mem[a] = op;
            tgt_mem[a] = t;
        end
    endtask
    initial begin
        for (int a = 0; a < PROG_WORDS; a++) begin
            op_mem[a] = OP_NEXT;
            tgt_mem[a] = '0;
        end
    end
    // Every word, rolling-code words too, fetches as code
    assign o_op = op_mem[i_addr];
    assign o_target = tgt_mem[i_addr];
    assign o_exec = exec_on;
endmodule

// file: verification/tb.sv
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
module tb;
    import prog_seq_pkg::*;
    logic i_clk = 0;
    logic i_rst_n = 0;
    logic i_exec;
    seq_op_t i_op;
    logic [PC_WIDTH-1:0] i_target;
    logic i_skip_taken = 0;
    logic i_slow_select = 0;
    logic i_enter_standby = 0;
    logic i_enter_halt = 0;
    logic i_irq_request = 0;
    logic i_irq_global_enable = 0;
    logic [5:0] i_wake_events = '0;
    logic i_port_b_bit0_ext_irq_pin = 0;
    logic i_ext_irq_pin_select = 0;
    logic i_ext_irq_enable = 0;
    logic [PC_WIDTH-1:0] o_pc;
    logic o_fetch, o_cycle_end, o_second_cycle, o_wake_irq, o_ext_irq, o_irq_taken;
    logic [1:0] o_phase;
    power_mode_t o_mode;
    int n_errors = 0;
    int compares = 0;
    int m_pc, sp, gap, fetches;
    int stk [8];
    bit second, took;
    bit model_on = 0;
    // ****************************************
    // Clock, partner and design
    // ****************************************
    initial forever #10 i_clk = ~i_clk;
    prog_mem_model prog_mem (.i_addr(o_pc), .o_op(i_op), .o_target(i_target), .o_exec(i_exec));
    program_sequencer DUT (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_exec(i_exec), .i_op(i_op), .i_target(i_target),
        .i_skip_taken(i_skip_taken), .i_slow_select(i_slow_select),
        .i_enter_standby(i_enter_standby), .i_enter_halt(i_enter_halt),
        .i_irq_request(i_irq_request), .i_irq_global_enable(i_irq_global_enable),
        .i_wake_events(i_wake_events), .i_port_b_bit0_ext_irq_pin(i_port_b_bit0_ext_irq_pin),
        .i_ext_irq_pin_select(i_ext_irq_pin_select), .i_ext_irq_enable(i_ext_irq_enable),
        .o_pc(o_pc), .o_fetch(o_fetch), .o_phase(o_phase), .o_cycle_end(o_cycle_end),
        .o_second_cycle(o_second_cycle), .o_mode(o_mode), .o_wake_irq(o_wake_irq),
        .o_ext_irq(o_ext_irq), .o_irq_taken(o_irq_taken)
    );
    // ****************************************
    // Helpers and reference model
    // ****************************************
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic push(input int v);
        stk[sp] = v;
        sp = (sp + 1) % 8;
    endtask
    task automatic step();
        seq_op_t op;
        int t, nxt;
        op = i_exec ? prog_mem.op_mem[m_pc] : OP_NEXT;
        t = prog_mem.tgt_mem[m_pc];
        nxt = (m_pc + 1) % PROG_WORDS;
        if (second) second = 0;
        else if (i_irq_request && i_irq_global_enable) begin
            push(nxt);
            m_pc = HW_IRQ_VECTOR;
            second = 1;
        end else begin
            second = 1;
            case (op)
                OP_NEXT: begin
                    m_pc = nxt;
                    second = 0;
                end
                OP_SKIP: begin
                    m_pc = i_skip_taken ? (m_pc + 2) % PROG_WORDS : nxt;
                    second = i_skip_taken;
                end
                OP_SHORT_CALL, OP_SHORT_ABS_CALL: begin
                    push(nxt);
                    m_pc = (m_pc & 'h300) | (t & 'hFF);
                end
                OP_SHORT_ABS_JUMP: m_pc = (m_pc & 'h300) | (t & 'hFF);
                OP_MEDIUM_JUMP: m_pc = (m_pc & 'h200) | (t & 'h1FF);
                OP_LONG_CALL: begin
                    push(nxt);
                    m_pc = t;
                end
                OP_LONG_JUMP: m_pc = t;
                OP_SOFT_IRQ: begin
                    push(nxt);
                    m_pc = SOFT_IRQ_VECTOR;
                end
                default: begin
                    sp = (sp + 7) % 8;
                    m_pc = stk[sp];
                end
            endcase
        end
    endtask
    // Compare at every cycle end, then draw new interrupt and skip levels
    always @(posedge i_clk) begin
        #2;
        if (model_on && i_rst_n) begin
            if (gap >= 0) gap++;
            fetches += o_fetch;
            if (o_cycle_end === 1'b1) begin
                took = !second && i_irq_request && i_irq_global_enable;
                check("pc", m_pc, o_pc);
                check("second cycle", second, o_second_cycle);
                check("irq taken", took, o_irq_taken);
                step();
                check("phase", 2'h3, o_phase);
                if (gap >= 0) check("cycle length", 4, gap);
                if (gap >= 0) check("fetches", 1, fetches);
                gap = 0;
                fetches = 0;
                prog_mem.exec_on = ($urandom % 8) != 0;
                i_irq_request = ($urandom % 8) == 0;
                i_irq_global_enable = 1'($urandom);
                i_skip_taken = 1'($urandom);
            end
        end
    end
    task automatic reset_dut();
        @(posedge i_clk);
        #2 i_rst_n = 0;
        repeat (3) @(posedge i_clk);
        #2 check("pc in reset", RESET_VECTOR, o_pc);
        m_pc = RESET_VECTOR;
        sp = 0;
        second = 0;
        gap = -1;
        fetches = 0;
        foreach (stk[i]) stk[i] = 0;
        i_rst_n = 1;
    endtask
    task automatic wake(input bit halt, input int ev, input logic [1:0] sel_en);
        power_mode_t slp;
        bit exp, woke, seen, ext_seen;
        slp = halt ? MODE_HALT : MODE_STANDBY;
        exp = (ev == 6) ? (sel_en == 2'h3) : (!halt || ev == 3 || ev == 4);
        woke = 0;
        seen = 0;
        ext_seen = 0;
        @(posedge i_clk);
        #2 i_slow_select = 1'($urandom);
        i_enter_halt = halt;
        i_enter_standby = !halt;
        for (int k = 0; k < 12 && o_mode !== slp; k++) begin
            @(posedge i_clk);
            #2;
        end
        check("sleep mode", slp, o_mode);
        {i_enter_halt, i_enter_standby} = 2'h0;
        {i_ext_irq_pin_select, i_ext_irq_enable} = sel_en;
        if (ev == 6) i_port_b_bit0_ext_irq_pin = 1;
        else i_wake_events[ev] = 1;
        for (int k = 0; k < 10; k++) begin
            @(posedge i_clk);
            #2 seen |= (o_wake_irq === 1'b1);
            woke |= (o_mode !== slp);
            ext_seen |= (o_ext_irq === 1'b1);
        end
        check("ext irq", exp && ev == 6, ext_seen);
        check("woken", exp, woke);
        check("wake irq", exp, seen);
        if (exp) check("run mode", i_slow_select ? MODE_SLOW : MODE_NORMAL, o_mode);
        i_wake_events = '0;
        i_port_b_bit0_ext_irq_pin = 0;
        if (!woke) i_wake_events = 6'h08;
        repeat (4) @(posedge i_clk);
        #2 i_wake_events = '0;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        int seed;
        seed = $urandom(40);
        #1;
        for (int a = 1; a < PROG_WORDS; a++) begin
            prog_mem.load(a, seq_op_t'($urandom_range(11, 0)), PC_WIDTH'($urandom) & 10'h3BF);
        end
        prog_mem.load(0, OP_LONG_JUMP, ROLLING_CODE_LO);
        prog_mem.load(ROLLING_CODE_LO, OP_NEXT, 10'h000);
        prog_mem.load(ROLLING_CODE_HI, OP_LONG_CALL, 10'h010);
        for (int a = 16; a < 23; a++) begin
            prog_mem.load(a, OP_SHORT_CALL, PC_WIDTH'(a + 1));
        end
        model_on = 1;
        reset_dut();
        repeat (1600) @(posedge i_clk);
        model_on = 0;
        reset_dut();
        repeat (3) @(posedge i_clk);
        #2 check("pc after reset", RESET_VECTOR, o_pc);
        for (int h = 0; h < 2; h++) begin
            for (int ev = 0; ev < WAKE_EVENTS; ev++) begin
                wake(h[0], ev, 2'h3);
            end
        end
        for (int k = 0; k < 3; k++) begin
            wake(1'b0, 6, k[1:0]);
        end
        complete_run();
    end
    initial begin
        #400000;
        n_errors++;
        complete_run();
    end
endmodule
